/* File: inc/pxc_defs.vh */
// Constants for the extended control register bank and the 100 Mb transmit path
`ifndef PXC_DEFS_VH
`define PXC_DEFS_VH

`define PXC_REG_EXT        5'h10
`define PXC_REG_NP         5'h08

`define PXC_BIT_OVR        15
`define PXC_BIT_ADDR_HI    10
`define PXC_BIT_ADDR_LO    6
`define PXC_BIT_SCR_TEST   5
`define PXC_BIT_NRZI       3
`define PXC_BIT_INVALID    2
`define PXC_BIT_SCR_DIS    0
`define PXC_BIT_NP_RSVD    14
`define PXC_NP_CODE_HI     10

`define PXC_EXT_RESET      16'h0008
`define PXC_LFSR_SEED      11'h7FF
`define PXC_IDLE_SYM       5'h1F
`define PXC_LOCK_BITS      4'hB
`define PXC_SYM_BITS       3'h5
`define PXC_FIFO_DEPTH     16

`endif

/* File: rtl/pxc_fifo.v */
// Synchronous FIFO with valid/ready on both sides, flip-flop storage
`timescale 1ns/1ps
module pxc_fifo #(
    parameter WIDTH = 5,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             core_clk,
    input  wire             rst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr;
    reg [AW-1:0]    rdPtr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    // Pointers wrap by index compare so DEPTH need not be a power of two
    always @(posedge core_clk) begin
        if (rst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end

    always @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule // pxc_fifo

/* File: rtl/pxc_enc4b5b.v */
// Nibble to five-bit symbol translation, standard or forced-invalid table
`timescale 1ns/1ps
module pxc_enc4b5b (
    input  wire [3:0] nibble,
    input  wire       txErr,
    input  wire       invalidEn,
    output wire [4:0] symbol
);
    function [4:0] std_code;
        input [3:0] n;
        begin
            case (n)
                4'h0: std_code = 5'h1E;
                4'h1: std_code = 5'h09;
                4'h2: std_code = 5'h14;
                4'h3: std_code = 5'h15;
                4'h4: std_code = 5'h0A;
                4'h5: std_code = 5'h0B;
                4'h6: std_code = 5'h0E;
                4'h7: std_code = 5'h0F;
                4'h8: std_code = 5'h12;
                4'h9: std_code = 5'h13;
                4'hA: std_code = 5'h16;
                4'hB: std_code = 5'h17;
                4'hC: std_code = 5'h1A;
                4'hD: std_code = 5'h1B;
                4'hE: std_code = 5'h1C;
                default: std_code = 5'h1D;
            endcase
        end
    endfunction

    function [4:0] bad_code;
        input [3:0] n;
        begin
            case (n)
                4'h8: bad_code = 5'h00;
                4'h9: bad_code = 5'h0D;
                4'hA: bad_code = 5'h0C;
                4'hB: bad_code = 5'h11;
                4'hC: bad_code = 5'h10;
                4'hD: bad_code = 5'h19;
                4'hE: bad_code = 5'h18;
                4'hF: bad_code = 5'h1F;
                default: bad_code = {1'b0, n};
            endcase
        end
    endfunction

    // Error input only matters once the test table is enabled
    assign symbol = (invalidEn & txErr) ? bad_code(nibble) : std_code(nibble);
endmodule // pxc_enc4b5b

/* File: rtl/pxc_ext_ctrl.v */
// Extended control register bank with the 100 Mb transmit and descramble path
`timescale 1ns/1ps
`include "pxc_defs.vh"
module pxc_ext_ctrl #(
    parameter FIFO_DEPTH = `PXC_FIFO_DEPTH
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire        swReset,
    input  wire        regWrEn,
    input  wire        regRdEn,
    input  wire [4:0]  regAddr,
    input  wire [15:0] regWrData,
    output reg  [15:0] regRdData,
    input  wire [15:0] partnerPage,
    input  wire        addr4_led_pin,
    input  wire        addr3_led_pin,
    input  wire        addr2_led_pin,
    input  wire        addr1_led_pin,
    input  wire        addr0_led_pin,
    input  wire        speed100,
    input  wire        txValid,
    output wire        txReady,
    input  wire [3:0]  txNibble,
    input  wire        txErr,
    output reg         txLine,
    input  wire        rxLine,
    output reg         rxData,
    output reg         rxLocked,
    output reg  [4:0]  phyAddr,
    output reg         overrideWriteEnable
);
    localparam ST_HUNT = 2'b01;
    localparam ST_LOCK = 2'b10;

    reg         scrTest;
    reg         nrziEn;
    reg         invalidEn;
    reg         scrDis;
    reg  [4:0]  addrMeta;
    reg  [4:0]  addrSync;
    reg         rxMeta;
    reg         rxSync;
    reg  [4:0]  shiftSym;
    reg  [2:0]  bitCnt;
    reg  [10:0] txLfsr;
    reg  [10:0] rxLfsr;
    reg  [3:0]  huntCnt;
    reg  [1:0]  rxState;
    reg  [1:0]  next_rxState;
    reg  [15:0] extValue;
    wire        cipherOn;
    wire        fifoValid;
    wire        fifoPop;
    wire [4:0]  fifoData;
    wire [4:0]  encSym;
    wire [4:0]  loadSym;
    wire        txKey;
    wire        txBit;
    wire        rxKey;
    wire        extWrite;

    function lfsr_key;
        input [10:0] s;
        begin
            lfsr_key = s[10] ^ s[8];
        end
    endfunction

    // Cipher needs both the 100 Mb rate and the scramble-disable bit clear
    assign cipherOn = speed100 & ~scrDis;
    assign extWrite = regWrEn & (regAddr == `PXC_REG_EXT);

    // Pins are asynchronous to core_clk; two stages before use
    always @(posedge core_clk) begin
        addrMeta <= {addr4_led_pin, addr3_led_pin, addr2_led_pin, addr1_led_pin,
                     addr0_led_pin};
        addrSync <= addrMeta;
        rxMeta   <= rxLine;
        rxSync   <= rxMeta;
    end

    // Address is captured only while hardware reset is held
    always @(posedge core_clk) begin
        if (rst) begin
            phyAddr <= addrSync;
        end
    end

    // Software reset restores control bits but never the address; writes skip it
    always @(posedge core_clk) begin
        if (rst | swReset) begin
            overrideWriteEnable <= 1'b0;
            scrTest             <= 1'b0;
            nrziEn              <= 1'b1;
            invalidEn           <= 1'b0;
            scrDis              <= 1'b0;
        end else if (regWrEn) begin
            // Any write ends the override window unless it re-arms it
            overrideWriteEnable <= extWrite & regWrData[`PXC_BIT_OVR];
            if (extWrite) begin
                scrTest   <= regWrData[`PXC_BIT_SCR_TEST];
                nrziEn    <= regWrData[`PXC_BIT_NRZI];
                invalidEn <= regWrData[`PXC_BIT_INVALID];
                scrDis    <= regWrData[`PXC_BIT_SCR_DIS];
            end
        end
    end

    always @* begin
        extValue                                   = 16'h0000;
        extValue[`PXC_BIT_OVR]                     = overrideWriteEnable;
        extValue[`PXC_BIT_ADDR_HI:`PXC_BIT_ADDR_LO] = phyAddr;
        extValue[`PXC_BIT_SCR_TEST]                = scrTest;
        extValue[`PXC_BIT_NRZI]                    = nrziEn;
        extValue[`PXC_BIT_INVALID]                 = invalidEn;
        extValue[`PXC_BIT_SCR_DIS]                 = scrDis;
    end

    // Read data is registered; unmapped addresses return zero
    always @(posedge core_clk) begin
        if (rst) begin
            regRdData <= 16'h0000;
        end else if (regRdEn) begin
            case (regAddr)
                `PXC_REG_EXT: regRdData <= extValue;
                `PXC_REG_NP: regRdData <= {partnerPage[15], 1'b0,
                                           partnerPage[13:0]};
                default: regRdData <= 16'h0000;
            endcase
        end
    end

    pxc_fifo #(
        .WIDTH (5),
        .DEPTH (FIFO_DEPTH),
        .AW    (4)
    ) u_fifo (
        .core_clk (core_clk),
        .rst      (rst),
        .inValid  (txValid),
        .inReady  (txReady),
        .inData   ({txErr, txNibble}),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoData)
    );

    pxc_enc4b5b u_enc (
        .nibble    (fifoData[3:0]),
        .txErr     (fifoData[4]),
        .invalidEn (invalidEn),
        .symbol    (encSym)
    );

    // One symbol takes five clocks, so the FIFO truly backs up
    assign fifoPop = fifoValid & (bitCnt == 3'h0);
    assign loadSym = fifoValid ? encSym : `PXC_IDLE_SYM;
    assign txKey   = lfsr_key(txLfsr);
    assign txBit   = shiftSym[4] ^ (cipherOn & txKey);

    always @(posedge core_clk) begin
        if (rst | swReset) begin
            shiftSym <= `PXC_IDLE_SYM;
            bitCnt   <= 3'h0;
            txLfsr   <= `PXC_LFSR_SEED;
            txLine   <= 1'b0;
        end else begin
            if (bitCnt == 3'h0) begin
                shiftSym <= loadSym;
                bitCnt   <= `PXC_SYM_BITS - 3'h1;
            end else begin
                shiftSym <= {shiftSym[3:0], 1'b0};
                bitCnt   <= bitCnt - 3'h1;
            end
            // Load cycle still sends the last bit, so all five bits reach the line
            txLfsr <= {txLfsr[9:0], txKey};
            if (speed100 & nrziEn) begin
                txLine <= txLine ^ txBit;
            end else begin
                txLine <= txBit;
            end
        end
    end

    // Descrambler locks by assuming idle ones while hunting
    assign rxKey = lfsr_key(rxLfsr);

    always @* begin
        next_rxState = rxState;
        case (rxState)
            ST_HUNT: begin
                if (huntCnt == `PXC_LOCK_BITS) begin
                    next_rxState = ST_LOCK;
                end
            end
            ST_LOCK: next_rxState = ST_LOCK;
            default: next_rxState = ST_HUNT;
        endcase
        if (scrTest | ~cipherOn) begin
            next_rxState = ST_HUNT;
        end
    end

    always @(posedge core_clk) begin
        if (rst | swReset) begin
            rxState  <= ST_HUNT;
            huntCnt  <= 4'h0;
            rxLfsr   <= `PXC_LFSR_SEED;
            rxData   <= 1'b0;
            rxLocked <= 1'b0;
        end else begin
            rxState  <= next_rxState;
            rxLocked <= (next_rxState == ST_LOCK) & cipherOn;
            if (~cipherOn) begin
                rxData  <= rxSync;
                huntCnt <= 4'h0;
            end else if (rxState == ST_LOCK && !scrTest) begin
                rxData <= rxSync ^ rxKey;
                rxLfsr <= {rxLfsr[9:0], rxKey};
            end else begin
                rxData  <= 1'b1;
                rxLfsr  <= {rxLfsr[9:0], ~rxSync};
                huntCnt <= (scrTest || huntCnt == `PXC_LOCK_BITS) ? 4'h0 : huntCnt + 4'h1;
            end
        end
    end
endmodule // pxc_ext_ctrl

/* File: sim/pxc_ext_ctrl_asserts.sv */
// Port-level checks for the extended control register bank
`timescale 1ns/1ps
`include "pxc_defs.vh"
module pxc_ext_ctrl_asserts (
    input wire        core_clk,
    input wire        rst,
    input wire        swReset,
    input wire        regWrEn,
    input wire        regRdEn,
    input wire [4:0]  regAddr,
    input wire [15:0] regWrData,
    input wire [15:0] regRdData,
    input wire [15:0] partnerPage,
    input wire        rxLocked,
    input wire [4:0]  phyAddr,
    input wire        overrideWriteEnable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    wire extWr = regWrEn && regAddr == `PXC_REG_EXT;
    wire extRd = regRdEn && regAddr == `PXC_REG_EXT;
    ovr_clear_a: assert property (
        regWrEn && !(extWr && regWrData[15]) |=> !overrideWriteEnable)
        else $error("override window stayed open");
    ovr_arm_a: assert property (
        extWr && regWrData[15] && !swReset |=> overrideWriteEnable)
        else $error("override window did not open");
    ovr_swrst_a: assert property (swReset |=> !overrideWriteEnable)
        else $error("override survived software reset");
    rsvd_zero_a: assert property (extRd |=> (regRdData & 16'h7812) == 16'h0000)
        else $error("reserved bit read as one");
    addr_read_a: assert property (
        extRd && !swReset |=> regRdData[10:6] == $past(phyAddr))
        else $error("address field differs from latch");
    addr_hold_a: assert property (1'b1 |=> $stable(phyAddr))
        else $error("address changed outside hardware reset");
    page_read_a: assert property (
        regRdEn && regAddr == `PXC_REG_NP && !swReset
        |=> regRdData == ($past(partnerPage) & 16'hBFFF))
        else $error("partner page read wrong");
    test_unlock_a: assert property (
        extWr && regWrData[5] && !swReset |=> ##[0:2] !rxLocked)
        else $error("descrambler kept lock in test mode");
endmodule // pxc_ext_ctrl_asserts

bind pxc_ext_ctrl pxc_ext_ctrl_asserts u_chk (.core_clk(core_clk), .rst(rst),
    .swReset(swReset), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .partnerPage(partnerPage),
    .rxLocked(rxLocked), .phyAddr(phyAddr), .overrideWriteEnable(overrideWriteEnable));

/* File: sim/pxc_sta_model.sv */
// Station manager model issuing register writes and reads
`timescale 1ns/1ps
`include "pxc_defs.vh"
module pxc_sta_model (
    input  wire        core_clk,
    output reg         regWrEn,
    output reg         regRdEn,
    output reg  [4:0]  regAddr,
    output reg  [15:0] regWrData,
    input  wire [15:0] regRdData
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 5'h00;
        regWrData = 16'h0000;
    end
    task wr(input [4:0] a, input [15:0] d);
        begin
            @(negedge core_clk);
            regAddr = a;
            // Reserved bits may trigger hidden functions, keep them zero
            regWrData = (a == `PXC_REG_EXT) ? (d & ~16'h7812) : d;
            regWrEn = 1'b1;
            @(negedge core_clk);
            regWrEn = 1'b0;
            regWrData = ~regWrData;
            regAddr = ~a;
        end
    endtask
    task rd(input [4:0] a, output [15:0] d);
        begin
            @(negedge core_clk);
            regAddr = a;
            regRdEn = 1'b1;
            @(negedge core_clk);
            regRdEn = 1'b0;
            regAddr = ~a;
            @(negedge core_clk);
            d = regRdData;
        end
    endtask
endmodule // pxc_sta_model

/* File: sim/pxc_ext_ctrl_tb.sv */
// Self-checking bench for the extended control register bank
`timescale 1ns/1ps
`include "pxc_defs.vh"
module pxc_ext_ctrl_tb;
    reg         core_clk;
    reg         rst;
    reg         swReset;
    reg  [15:0] partnerPage;
    reg  [4:0]  ledPins;
    reg         speed100;
    reg         txValid;
    reg  [3:0]  txNibble;
    reg         txErr;
    wire        regWrEn;
    wire        regRdEn;
    wire [4:0]  regAddr;
    wire [15:0] regWrData;
    wire [15:0] regRdData;
    wire        txReady;
    wire        txLine;
    wire        rxLocked;
    wire        overrideWriteEnable;
    reg  [15:0] rv;
    integer     errorCnt;
    integer     checked;
    integer     n;
    integer     cnt;
    reg         hit;

    pxc_sta_model sta (.core_clk(core_clk), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData));
    // Loopback lets the descrambler hunt on our own scrambled idles
    pxc_ext_ctrl DUT (.core_clk(core_clk), .rst(rst), .swReset(swReset),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .partnerPage(partnerPage), .addr4_led_pin(ledPins[4]),
        .addr3_led_pin(ledPins[3]), .addr2_led_pin(ledPins[2]), .addr1_led_pin(ledPins[1]),
        .addr0_led_pin(ledPins[0]), .speed100(speed100), .txValid(txValid),
        .txReady(txReady), .txNibble(txNibble), .txErr(txErr), .txLine(txLine),
        .rxLine(txLine), .rxData(), .rxLocked(rxLocked), .phyAddr(),
        .overrideWriteEnable(overrideWriteEnable));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                errorCnt = errorCnt + 1;
                $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task testDone;
        begin
            if (errorCnt == 0 && checked > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task push(input [3:0] nib, input err);
        begin
            @(negedge core_clk);
            txNibble = nib;
            txErr = err;
            txValid = 1'b1;
            @(negedge core_clk);
            txValid = 1'b0;
        end
    endtask
    // Symbol framing is loose, so look for the pattern anywhere nearby
    task scan(input [4:0] pat, output found);
        reg [4:0] sh;
        integer   i;
        begin
            sh = 5'h1F;
            found = 1'b0;
            for (i = 0; i < 40; i = i + 1) begin
                @(negedge core_clk);
                sh = {sh[3:0], txLine};
                if (sh === pat) found = 1'b1;
            end
        end
    endtask
    task lineChanges(input [15:0] ext, output integer c);
        integer i;
        begin
            sta.wr(`PXC_REG_EXT, ext);
            repeat (10) @(negedge core_clk);
            c = 0;
            for (i = 0; i < 20; i = i + 1) begin
                @(negedge core_clk);
                if (txLine !== 1'b0 && txLine !== 1'b1) c = c + 100;
                if (i > 0 && txLine !== hit) c = c + 1;
                hit = txLine;
            end
        end
    endtask
    function [4:0] invSym(input [3:0] v);
        case (v)
            4'h8: invSym = 5'h00;
            4'h9: invSym = 5'h0D;
            4'hA: invSym = 5'h0C;
            4'hB: invSym = 5'h11;
            4'hC: invSym = 5'h10;
            4'hD: invSym = 5'h19;
            4'hE: invSym = 5'h18;
            default: invSym = {1'b0, v};
        endcase
    endfunction

    task tRegs;
        begin
            sta.rd(`PXC_REG_EXT, rv);
            check(rv, 16'h0588);
            sta.rd(5'h03, rv);
            check(rv, 16'h0000);
            ledPins = 5'h09;
            @(negedge core_clk);
            swReset = 1'b1;
            @(negedge core_clk);
            swReset = 1'b0;
            sta.rd(`PXC_REG_EXT, rv);
            check(rv, 16'h0588);
            sta.wr(`PXC_REG_EXT, 16'h07C8);
            sta.rd(`PXC_REG_EXT, rv);
            check(rv, 16'h0588);
            rst = 1'b1;
            repeat (4) @(negedge core_clk);
            rst = 1'b0;
            sta.rd(`PXC_REG_EXT, rv);
            check(rv, 16'h0248);
        end
    endtask
    task tOverride;
        begin
            sta.wr(`PXC_REG_EXT, 16'h8008);
            check({15'h0000, overrideWriteEnable}, 16'h0001);
            sta.wr(`PXC_REG_NP, 16'h1234);
            check({15'h0000, overrideWriteEnable}, 16'h0000);
            sta.rd(`PXC_REG_EXT, rv);
            check(rv, 16'h0248);
            partnerPage = 16'hFFFF;
            sta.rd(`PXC_REG_NP, rv);
            check(rv, 16'hBFFF);
            partnerPage = 16'h0555;
            sta.rd(`PXC_REG_NP, rv);
            check(rv, 16'h0555);
        end
    endtask
    task tCodes;
        begin
            sta.wr(`PXC_REG_EXT, 16'h000C);
            for (n = 0; n < 15; n = n + 1) begin
                push(n[3:0], 1'b1);
                scan(invSym(n[3:0]), hit);
                check({15'h0000, hit}, 16'h0001);
            end
            sta.wr(`PXC_REG_EXT, 16'h0008);
            push(4'h1, 1'b1);
            scan(5'h09, hit);
            check({15'h0000, hit}, 16'h0001);
        end
    endtask
    task tLine;
        begin
            speed100 = 1'b1;
            lineChanges(16'h0001, cnt);
            check(cnt, 16'h0000);
            lineChanges(16'h0009, cnt);
            check(cnt >= 12, 16'h0001);
            lineChanges(16'h0000, cnt);
            check(cnt > 0 && cnt < 100, 16'h0001);
            n = 0;
            while (rxLocked !== 1'b1 && n < 400) begin
                @(negedge core_clk);
                n = n + 1;
            end
            check({15'h0000, rxLocked}, 16'h0001);
            sta.wr(`PXC_REG_EXT, 16'h0020);
            repeat (2) @(negedge core_clk);
            check({15'h0000, rxLocked}, 16'h0000);
            speed100 = 1'b0;
            lineChanges(16'h0000, cnt);
            check(cnt, 16'h0000);
        end
    endtask
    task tFifo;
        begin
            @(negedge core_clk);
            txNibble = 4'h5;
            txErr = 1'b0;
            txValid = 1'b1;
            n = 0;
            while (txReady === 1'b1 && n < 40) begin
                @(negedge core_clk);
                n = n + 1;
            end
            txValid = 1'b0;
            check({15'h0000, txReady}, 16'h0000);
            if (n >= 40) begin
                errorCnt = errorCnt + 1;
                testDone;
            end
            repeat (120) @(negedge core_clk);
            check({15'h0000, txReady}, 16'h0001);
        end
    endtask

    initial begin
        rst = 1'b1;
        swReset = 1'b0;
        partnerPage = 16'h0000;
        ledPins = 5'h16;
        speed100 = 1'b0;
        txValid = 1'b0;
        txNibble = 4'h0;
        txErr = 1'b0;
        hit = 1'b0;
        errorCnt = 0;
        checked = 0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        tRegs;
        tOverride;
        tCodes;
        tLine;
        tFifo;
        testDone;
    end
endmodule // pxc_ext_ctrl_tb
